// *** logic/fbsh_cfg.svh ***
`ifndef FBSH_CFG_SVH
`define FBSH_CFG_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define FBSH_BLK_BYTES   128
`define FBSH_FLASH_BYTES 32768
`define FBSH_SRAM_BYTES  2048
`define FBSH_TBL_BYTES   8

// ----------------------------------------
// function codes and keys
// ----------------------------------------
`define FBSH_FN_READ  8'h01
`define FBSH_FN_WRITE 8'h02
`define FBSH_FN_ERASE 8'h03
`define FBSH_FN_TABLE 8'h06
`define FBSH_FIRST_KEY_BYTE_VAL 8'h3A
`define FBSH_SP_ADJ   8'h03

// ----------------------------------------
// page-0 parameter block and registers
// ----------------------------------------
`define FBSH_ADR_FIRST_KEY_BYTE    8'hF8
`define FBSH_ADR_SECOND_KEY_BYTE    8'hF9
`define FBSH_ADR_BLK     8'hFA
`define FBSH_ADR_PTR     8'hFB
`define FBSH_REG_RD_PAGE 8'hD4
`define FBSH_REG_WR_PAGE 8'hD5
`define FBSH_PAGE_RST    8'h00

// ----------------------------------------
// return codes and protection modes
// ----------------------------------------
`define FBSH_RET_OK    8'h00
`define FBSH_RET_PROT  8'h01
`define FBSH_ERASE_VAL 8'h00
`define FBSH_PROT_RD   2'b01
`define FBSH_PROT_IW   2'b11
`endif

// *** logic/fbsh_pkg.sv ***
package fbsh_pkg;
  typedef logic [7:0] fbsh_byte_type;
  typedef logic [1:0] fbsh_prot_type;
  // service sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_PARAM, S_CHECK, S_XFER, S_PROG, S_TABLE, S_STAT1, S_STAT2, S_DONE, S_HALT
  } fbsh_state_type;
  // caller sequencer states
  typedef enum logic [1:0] {H_IDLE, H_FILL, H_CALL, H_WAIT} fbsh_hstate_type;
endpackage : fbsh_pkg

// *** logic/fbsh_link_if.sv ***
interface fbsh_link_if;
  import fbsh_pkg::*;
  // call request and completion
  logic          call_valid;
  fbsh_byte_type call_func;
  fbsh_byte_type call_sp;
  logic          call_done;
  fbsh_byte_type call_acc;
  logic          halted;
  // sram access by the service
  logic          mem_req;
  logic          mem_we;
  logic [10:0]   mem_addr;
  fbsh_byte_type mem_wdata;
  logic          mem_ack;
  fbsh_byte_type mem_rdata;
  // page select registers
  fbsh_byte_type rd_page;
  fbsh_byte_type wr_page;

  modport dev (input call_valid, call_func, call_sp, mem_ack, mem_rdata, rd_page, wr_page,
               output call_done, call_acc, halted, mem_req, mem_we, mem_addr, mem_wdata);
  modport host (output call_valid, call_func, call_sp, mem_ack, mem_rdata, rd_page, wr_page,
                input call_done, call_acc, halted, mem_req, mem_we, mem_addr, mem_wdata);
endinterface : fbsh_link_if

// *** logic/fbsh_device.sv ***
`include "fbsh_cfg.svh"

// ----------------------------------------
// byte fifo between source and sink stages
// ----------------------------------------
module fbsh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0]      count_reg;
  logic [AW-1:0]    wp_reg;
  logic [AW-1:0]    rp_reg;
  logic             push;
  logic             pop;

  // pointers wrap naturally, so DEPTH must be a power of two
  assign in_ready  = count_reg != (AW + 1)'(DEPTH);
  assign out_valid = count_reg != '0;
  assign out_data  = mem[rp_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_reg    <= '0;
      rp_reg    <= '0;
      count_reg <= '0;
    end else begin
      if (push) wp_reg <= wp_reg + 1'b1;
      if (pop) rp_reg <= rp_reg + 1'b1;
      if (push && !pop) count_reg <= count_reg + 1'b1;
      else if (pop && !push) count_reg <= count_reg - 1'b1;
    end
  end
endmodule : fbsh_fifo

// ----------------------------------------
// flash block service end
// ----------------------------------------
module fbsh_device #(
  parameter logic [255:0]       MFG_TABLES  = '0,
  parameter fbsh_pkg::fbsh_byte_type REVISION_ID = 8'h00  // arbitrary value
) (
  // link to the caller
  fbsh_link_if.dev                 link,
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  // external programmer
  input  wire logic                ext_prog_we,
  input  wire logic [14:0]         ext_prog_addr,
  input  fbsh_pkg::fbsh_byte_type  ext_prog_data,
  input  wire logic                ext_prot_we,
  input  wire logic [5:0]          ext_prot_idx,
  input  fbsh_pkg::fbsh_byte_type  ext_prot_data,
  // direct flash load path
  input  wire logic [14:0]         load_addr,
  output fbsh_pkg::fbsh_byte_type  load_data
);
  import fbsh_pkg::*;

  fbsh_byte_type  flash_mem [0:`FBSH_FLASH_BYTES-1];
  fbsh_byte_type  prot_mem  [0:63];
  fbsh_byte_type  latch_mem [0:`FBSH_BLK_BYTES-1];
  fbsh_state_type state_reg;
  fbsh_byte_type  func_reg;
  fbsh_byte_type  sp_reg;
  fbsh_byte_type  first_key_byte_reg;
  fbsh_byte_type  second_key_byte_reg;
  fbsh_byte_type  blk_reg;
  fbsh_byte_type  ptr_reg;
  fbsh_byte_type  code_reg;
  fbsh_byte_type  acc_reg;
  logic [7:0]     src_cnt_reg;
  logic [7:0]     snk_cnt_reg;
  logic           mreq_reg;
  logic           mwe_reg;
  logic [10:0]    maddr_reg;
  fbsh_byte_type  mwdata_reg;
  logic           done_reg;
  logic           halt_reg;
  fbsh_byte_type  prot_byte;
  fbsh_prot_type  prot_mode;
  logic           is_read;
  logic           in_valid;
  logic           in_ready;
  fbsh_byte_type  in_data;
  logic           out_valid;
  logic           out_ready;
  fbsh_byte_type  out_data;
  logic           rd_issue;
  logic           pop;
  fbsh_byte_type  tbl_byte;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  assign prot_byte = prot_mem[blk_reg[7:2]];
  assign prot_mode = prot_byte[{blk_reg[1:0], 1'b0} +: 2];
  assign is_read   = func_reg == `FBSH_FN_READ;
  assign tbl_byte  = MFG_TABLES[{blk_reg[1:0], src_cnt_reg[2:0], 3'b000} +: 8];
  assign pop       = out_valid & out_ready;
  // write op pulls sram bytes only while the fifo has room
  assign rd_issue  = (state_reg == S_XFER) && !is_read && !mreq_reg && !src_cnt_reg[7] && in_ready;

  // read op streams flash out, write op streams sram in
  assign in_data   = is_read ? flash_mem[{blk_reg, src_cnt_reg[6:0]}] : link.mem_rdata;
  assign in_valid  = (state_reg == S_XFER) && (is_read ? !src_cnt_reg[7] : link.mem_ack);
  assign out_ready = (state_reg == S_XFER) && (is_read ? !mreq_reg : 1'b1);

  fbsh_fifo #(
    .WIDTH (8),
    .DEPTH (8)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  // ----------------------------------------
  // service sequencer
  // ----------------------------------------
  // one call at a time; a new request is ignored until done
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= S_IDLE;
      func_reg  <= 8'h00;
      sp_reg    <= 8'h00;
      code_reg  <= 8'h00;
      acc_reg   <= 8'h00;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (link.call_valid) begin
            func_reg  <= link.call_func;
            sp_reg    <= link.call_sp;
            state_reg <= S_PARAM;
          end
        end
        S_PARAM: begin
          if (link.mem_ack && src_cnt_reg == 8'h03) state_reg <= S_CHECK;
        end
        S_CHECK: begin
          acc_reg  <= 8'h00;
          code_reg <= `FBSH_RET_OK;
          if (first_key_byte_reg != `FBSH_FIRST_KEY_BYTE_VAL || second_key_byte_reg != sp_reg + `FBSH_SP_ADJ) begin
            state_reg <= S_HALT;
          end else begin
            case (func_reg)
              `FBSH_FN_READ: begin
                if (prot_mode == `FBSH_PROT_RD) begin
                  code_reg  <= `FBSH_RET_PROT;
                  state_reg <= S_STAT1;
                end else begin
                  state_reg <= S_XFER;
                end
              end
              `FBSH_FN_WRITE: begin
                if (prot_mode == `FBSH_PROT_IW) begin
                  code_reg  <= `FBSH_RET_PROT;
                  state_reg <= S_STAT1;
                end else begin
                  state_reg <= S_XFER;
                end
              end
              `FBSH_FN_ERASE: begin
                if (prot_mode == `FBSH_PROT_IW) begin
                  code_reg  <= `FBSH_RET_PROT;
                  state_reg <= S_STAT1;
                end else begin
                  state_reg <= S_PROG;
                end
              end
              `FBSH_FN_TABLE: state_reg <= S_TABLE;
              default: state_reg <= S_HALT;
            endcase
          end
        end
        S_XFER: begin
          if (snk_cnt_reg[7] && (is_read ? !mreq_reg : 1'b1)) begin
            state_reg <= is_read ? S_STAT1 : S_PROG;
          end
        end
        S_PROG: begin
          if (src_cnt_reg == 8'h7F) state_reg <= S_STAT1;
        end
        S_TABLE: begin
          acc_reg <= REVISION_ID;
          if (link.mem_ack && src_cnt_reg == 8'h07) state_reg <= S_DONE;
        end
        S_STAT1: if (link.mem_ack) state_reg <= S_STAT2;
        S_STAT2: if (link.mem_ack) state_reg <= S_DONE;
        S_DONE: state_reg <= S_IDLE;
        default: state_reg <= S_HALT;  // halted until reset
      endcase
    end
  end

  // parameter block capture
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_key_byte_reg <= 8'h00;
      second_key_byte_reg <= 8'h00;
      blk_reg  <= 8'h00;
      ptr_reg  <= 8'h00;
    end else if (state_reg == S_PARAM && link.mem_ack) begin
      case (src_cnt_reg[1:0])
        2'd0: first_key_byte_reg <= link.mem_rdata;
        2'd1: second_key_byte_reg <= link.mem_rdata;
        2'd2: blk_reg  <= link.mem_rdata;
        default: ptr_reg <= link.mem_rdata;
      endcase
    end
  end

  // source counter: param index, flash byte, latch byte, table byte
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_cnt_reg <= 8'h00;
    end else begin
      case (state_reg)
        S_PARAM, S_TABLE: if (link.mem_ack) src_cnt_reg <= src_cnt_reg + 8'h01;
        S_XFER: begin
          // a read keeps its count, else the idle source refills the fifo with stale bytes
          if (snk_cnt_reg[7] && !is_read) src_cnt_reg <= 8'h00;
          else if (rd_issue || (in_valid && in_ready && is_read)) src_cnt_reg <= src_cnt_reg + 8'h01;
        end
        S_PROG: src_cnt_reg <= src_cnt_reg + 8'h01;
        default: src_cnt_reg <= 8'h00;
      endcase
    end
  end

  // sink counter counts bytes leaving the fifo
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      snk_cnt_reg <= 8'h00;
    end else if (state_reg != S_XFER) begin
      snk_cnt_reg <= 8'h00;
    end else if (pop) begin
      snk_cnt_reg <= snk_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------
  // sram requester, one access outstanding
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mreq_reg   <= 1'b0;
      mwe_reg    <= 1'b0;
      maddr_reg  <= 11'h000;
      mwdata_reg <= 8'h00;
    end else if (link.mem_ack) begin
      mreq_reg <= 1'b0;
    end else if (!mreq_reg) begin
      case (state_reg)
        S_PARAM: begin
          mreq_reg  <= !src_cnt_reg[2];
          mwe_reg   <= 1'b0;
          maddr_reg <= {3'b000, `FBSH_ADR_FIRST_KEY_BYTE + src_cnt_reg};
        end
        S_XFER: begin
          if (is_read && out_valid) begin
            mreq_reg   <= 1'b1;
            mwe_reg    <= 1'b1;
            maddr_reg  <= {link.wr_page[2:0], ptr_reg + snk_cnt_reg};
            mwdata_reg <= out_data;
          end else if (rd_issue) begin
            mreq_reg  <= 1'b1;
            mwe_reg   <= 1'b0;
            maddr_reg <= {link.rd_page[2:0], ptr_reg + src_cnt_reg};
          end
        end
        S_TABLE: begin
          mreq_reg   <= !src_cnt_reg[3];
          mwe_reg    <= 1'b1;
          maddr_reg  <= {3'b000, `FBSH_ADR_FIRST_KEY_BYTE + src_cnt_reg};
          mwdata_reg <= tbl_byte;
        end
        S_STAT1: begin
          mreq_reg   <= 1'b1;
          mwe_reg    <= 1'b1;
          maddr_reg  <= {3'b000, `FBSH_ADR_FIRST_KEY_BYTE};
          mwdata_reg <= code_reg;
        end
        S_STAT2: begin
          mreq_reg   <= 1'b1;
          mwe_reg    <= 1'b1;
          maddr_reg  <= {3'b000, `FBSH_ADR_SECOND_KEY_BYTE};
          mwdata_reg <= 8'h00;
        end
        default: mreq_reg <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // flash, page latch and protection store
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (state_reg == S_XFER && !is_read && pop) begin
      latch_mem[snk_cnt_reg[6:0]] <= out_data;
    end
  end

  // program or erase in place, no verify pass
  always_ff @(posedge ref_clk) begin
    if (state_reg == S_PROG) begin
      flash_mem[{blk_reg, src_cnt_reg[6:0]}] <= (func_reg == `FBSH_FN_ERASE) ? `FBSH_ERASE_VAL
                                                : latch_mem[src_cnt_reg[6:0]];
    end else if (ext_prog_we) begin
      flash_mem[ext_prog_addr] <= ext_prog_data;
    end
  end

  // no service path writes here
  always_ff @(posedge ref_clk) begin
    if (ext_prot_we) begin
      prot_mem[ext_prot_idx] <= ext_prot_data;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      load_data <= 8'h00;
      done_reg  <= 1'b0;
      halt_reg  <= 1'b0;
    end else begin
      load_data <= flash_mem[load_addr];
      done_reg  <= state_reg == S_DONE;
      halt_reg  <= halt_reg | (state_reg == S_HALT);
    end
  end

  assign link.call_done = done_reg;
  assign link.call_acc  = acc_reg;
  assign link.halted    = halt_reg;
  assign link.mem_req   = mreq_reg;
  assign link.mem_we    = mwe_reg;
  assign link.mem_addr  = maddr_reg;
  assign link.mem_wdata = mwdata_reg;
endmodule : fbsh_device

// *** logic/fbsh_host.sv ***
`include "fbsh_cfg.svh"

// ----------------------------------------
// caller end: sram, page registers, calls
// ----------------------------------------
module fbsh_host (
  // link to the service
  fbsh_link_if.host                link,
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                sys_rst,
  // call request
  input  wire logic                call_start,
  input  fbsh_pkg::fbsh_byte_type  call_func,
  input  fbsh_pkg::fbsh_byte_type  call_sp,
  input  fbsh_pkg::fbsh_byte_type  call_block,
  input  fbsh_pkg::fbsh_byte_type  call_ptr,
  // call status
  output logic                     call_busy,
  output logic                     call_done,
  output logic                     call_refused,
  output fbsh_pkg::fbsh_byte_type  call_acc,
  output logic                     call_halted,
  // page registers
  input  wire logic                reg_we,
  input  fbsh_pkg::fbsh_byte_type  reg_addr,
  input  fbsh_pkg::fbsh_byte_type  reg_wdata,
  output fbsh_pkg::fbsh_byte_type  reg_rdata,
  // user sram port
  input  wire logic                sram_we,
  input  wire logic [10:0]         sram_addr,
  input  fbsh_pkg::fbsh_byte_type  sram_wdata,
  output fbsh_pkg::fbsh_byte_type  sram_rdata
);
  import fbsh_pkg::*;

  fbsh_byte_type   sram_mem [0:`FBSH_SRAM_BYTES-1];
  fbsh_hstate_type hstate_reg;
  logic [1:0]      fill_cnt_reg;
  fbsh_byte_type   func_reg;
  fbsh_byte_type   sp_reg;
  fbsh_byte_type   blk_reg;
  fbsh_byte_type   ptr_reg;
  fbsh_byte_type   rd_page_reg;
  fbsh_byte_type   wr_page_reg;
  logic            ack_reg;
  fbsh_byte_type   rdata_reg;
  logic            valid_reg;
  logic            erased_reg;
  fbsh_byte_type   erased_blk_reg;
  fbsh_byte_type   fill_byte;
  logic            repeat_erase;

  // keys and parameter block for page 0
  always_comb begin
    case (fill_cnt_reg)
      2'd0: fill_byte = `FBSH_FIRST_KEY_BYTE_VAL;
      2'd1: fill_byte = sp_reg + `FBSH_SP_ADJ;
      2'd2: fill_byte = blk_reg;
      default: fill_byte = ptr_reg;
    endcase
  end
  assign repeat_erase = call_func == `FBSH_FN_ERASE && erased_reg && erased_blk_reg == call_block;

  // ----------------------------------------
  // call sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hstate_reg   <= H_IDLE;
      fill_cnt_reg <= 2'd0;
      func_reg     <= 8'h00;
      sp_reg       <= 8'h00;
      blk_reg      <= 8'h00;
      ptr_reg      <= 8'h00;
      valid_reg    <= 1'b0;
      call_busy    <= 1'b0;
      call_refused <= 1'b0;
    end else begin
      valid_reg    <= 1'b0;
      call_refused <= 1'b0;
      case (hstate_reg)
        H_IDLE: begin
          if (call_start && repeat_erase) begin
            call_refused <= 1'b1;
          end else if (call_start) begin
            func_reg     <= call_func;
            sp_reg       <= call_sp;
            blk_reg      <= call_block;
            ptr_reg      <= call_ptr;
            fill_cnt_reg <= 2'd0;
            call_busy    <= 1'b1;
            hstate_reg   <= H_FILL;
          end
        end
        H_FILL: begin
          fill_cnt_reg <= fill_cnt_reg + 2'd1;
          if (fill_cnt_reg == 2'd3) hstate_reg <= H_CALL;
        end
        H_CALL: begin
          valid_reg  <= 1'b1;
          hstate_reg <= H_WAIT;
        end
        default: begin
          // a halted service keeps the caller held
          if (link.call_done) begin
            call_busy  <= 1'b0;
            hstate_reg <= H_IDLE;
          end
        end
      endcase
    end
  end

  // erase history for the repeat guard; a write clears it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      erased_reg     <= 1'b0;
      erased_blk_reg <= 8'h00;
    end else if (hstate_reg == H_CALL) begin
      if (func_reg == `FBSH_FN_ERASE) begin
        erased_reg     <= 1'b1;
        erased_blk_reg <= blk_reg;
      end else if (func_reg == `FBSH_FN_WRITE) begin
        erased_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // sram: service, then fill, then user
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (link.mem_req && link.mem_we && !ack_reg) begin
      sram_mem[link.mem_addr] <= link.mem_wdata;
    end else if (hstate_reg == H_FILL) begin
      sram_mem[{3'b000, `FBSH_ADR_FIRST_KEY_BYTE + {6'h00, fill_cnt_reg}}] <= fill_byte;
    end else if (hstate_reg == H_IDLE && sram_we) begin
      sram_mem[sram_addr] <= sram_wdata;
    end
  end

  // one-cycle ack per request
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg    <= 1'b0;
      rdata_reg  <= 8'h00;
      sram_rdata <= 8'h00;
    end else begin
      ack_reg    <= link.mem_req && !ack_reg;
      rdata_reg  <= sram_mem[link.mem_addr];
      sram_rdata <= sram_mem[sram_addr];
    end
  end

  // ----------------------------------------
  // page registers and status
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_page_reg <= `FBSH_PAGE_RST;
      wr_page_reg <= `FBSH_PAGE_RST;
      reg_rdata   <= 8'h00;
    end else begin
      if (reg_we && reg_addr == `FBSH_REG_RD_PAGE) rd_page_reg <= reg_wdata;
      else if (reg_we && reg_addr == `FBSH_REG_WR_PAGE) wr_page_reg <= reg_wdata;
      if (reg_addr == `FBSH_REG_RD_PAGE) reg_rdata <= rd_page_reg;
      else if (reg_addr == `FBSH_REG_WR_PAGE) reg_rdata <= wr_page_reg;
      else reg_rdata <= 8'h00;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      call_done   <= 1'b0;
      call_acc    <= 8'h00;
      call_halted <= 1'b0;
    end else begin
      call_done   <= link.call_done;
      call_halted <= link.halted;
      if (link.call_done) call_acc <= link.call_acc;
    end
  end

  assign link.call_valid = valid_reg;
  assign link.call_func  = func_reg;
  assign link.call_sp    = sp_reg;
  assign link.mem_ack    = ack_reg;
  assign link.mem_rdata  = rdata_reg;
  assign link.rd_page    = rd_page_reg;
  assign link.wr_page    = wr_page_reg;
endmodule : fbsh_host

// *** tb/fbsh_assertions.sv ***
// ----------------------------------------
// link checker
// ----------------------------------------
module fbsh_assertions (
  // clock and reset
  input wire logic                    ref_clk,
  input wire logic                    sys_rst,
  // link signals
  input wire logic                    call_valid,
  input wire fbsh_pkg::fbsh_byte_type call_func,
  input wire logic                    call_done,
  input wire fbsh_pkg::fbsh_byte_type call_acc,
  input wire logic                    halted,
  input wire logic                    mem_req,
  input wire logic                    mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  import fbsh_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // call with a known code
  sequence s_call;
    call_valid && call_func inside {8'h01, 8'h02, 8'h03, 8'h06};
  endsequence
  a_ack_next: assert property ($rose(mem_req) |=> mem_ack) else $error("late ack");
  a_req_held: assert property (mem_req && !mem_ack |=> mem_req) else $error("req dropped");
  a_done_pulse: assert property (call_done |=> !call_done) else $error("long done");
  a_call_ends: assert property (s_call |-> ##[1:1000] call_done) else $error("no done");
  a_one_call: assert property (s_call |=> !call_valid until call_done) else $error("overlap");
  a_halt_stays: assert property (halted |=> halted && !call_done) else $error("halt lost");
  a_bad_code: assert property (call_valid && !(call_func inside {8'h01, 8'h02, 8'h03, 8'h06})
    |-> ##[1:60] halted) else $error("no halt");
  a_ok_acc: assert property (call_done && call_func inside {8'h01, 8'h02, 8'h03}
    |-> call_acc == 8'h00) else $error("bad acc");
endmodule : fbsh_assertions

// *** tb/testbench.sv ***
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fbsh_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, call_start = 1'b0, reg_we = 1'b0, sram_we = 1'b0;
  logic ext_prog_we = 1'b0, ext_prot_we = 1'b0, call_busy, call_done, call_refused, call_halted;
  logic [14:0] ext_prog_addr = '0, load_addr = '0;
  logic [10:0] sram_addr = '0;
  logic [5:0] ext_prot_idx = '0;
  fbsh_byte_type call_func = '0, call_block = '0, call_acc, reg_addr = '0, reg_wdata = '0, reg_rdata;
  fbsh_byte_type call_sp = 8'h20, call_ptr = 8'h10, sram_wdata = '0, sram_rdata, load_data;
  fbsh_byte_type ext_prog_data = '0, ext_prot_data = '0;
  int n_mismatch = 0, n_compared = 0, cycles = 0;
  // byte b of table t holds the value 8t+b
  localparam logic [255:0] TBL_IMAGE = 256'h1F1E1D1C1B1A191817161514131211100F0E0D0C0B0A09080706050403020100;
  fbsh_link_if link ();
  always #4 ref_clk = ~ref_clk;
  fbsh_device #(.REVISION_ID(8'h5C), .MFG_TABLES(TBL_IMAGE))
    i_fbsh_device (.link, .ref_clk, .sys_rst, .ext_prog_we, .ext_prog_addr,
    .ext_prog_data, .ext_prot_we, .ext_prot_idx, .ext_prot_data, .load_addr, .load_data);
  fbsh_host i_fbsh_host (.link, .ref_clk, .sys_rst, .call_start, .call_func, .call_sp, .call_block, .call_ptr,
    .call_busy, .call_done, .call_refused, .call_acc, .call_halted, .reg_we, .reg_addr, .reg_wdata,
    .reg_rdata, .sram_we, .sram_addr, .sram_wdata, .sram_rdata);
  fbsh_assertions i_fbsh_assertions (.ref_clk, .sys_rst, .call_valid(link.call_valid),
    .call_func(link.call_func), .call_done(link.call_done), .call_acc(link.call_acc),
    .halted(link.halted), .mem_req(link.mem_req), .mem_ack(link.mem_ack));
  task automatic tick(int n = 1);
    repeat (n) @(negedge ref_clk);
  endtask : tick
  // page register write, then read back
  task automatic reg_rw(fbsh_byte_type a, fbsh_byte_type d, fbsh_byte_type e);
    reg_we = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick();
    reg_we = 1'b0;
    tick();
    `CHK(reg_rdata, e)
  endtask : reg_rw
  task automatic chk_sram(logic [10:0] a, fbsh_byte_type e);
    sram_addr = a;
    tick();
    `CHK(sram_rdata, e)
  endtask : chk_sram
  task automatic chk_flash(logic [14:0] a, fbsh_byte_type e);
    load_addr = a;
    tick();
    `CHK(load_data, e)
  endtask : chk_flash
  // external programmer sets one protection byte
  task automatic set_prot(logic [5:0] i, fbsh_byte_type d);
    ext_prot_we = 1'b1;
    ext_prot_idx = i;
    ext_prot_data = d;
    tick();
    ext_prot_we = 1'b0;
  endtask : set_prot
  // one call; bounded wait, since a halt never completes
  task automatic do_call(fbsh_byte_type f, fbsh_byte_type b, fbsh_byte_type ea, fbsh_byte_type ef);
    call_start = 1'b1;
    call_func = f;
    call_block = b;
    tick();
    call_start = 1'b0;
    for (int i = 0; i < 2000 && call_done !== 1'b1 && call_halted !== 1'b1; i++) tick();
    tick(2);
    if (call_halted !== 1'b1) begin
      `CHK(call_acc, ea)
      chk_sram(11'h0F8, ef);
    end
  endtask : do_call
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  // hang guard, well above the few thousand cycles needed
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    tick(3);
    sys_rst = 1'b0;
    reg_rw(8'hD5, 8'h01, 8'h01);
    reg_rw(8'hD4, 8'h01, 8'h01);
    reg_rw(8'hE0, 8'h33, 8'h00);
    ext_prog_we = 1'b1;
    for (int i = 0; i < 128; i++) begin
      ext_prog_addr = 15'(5 * 128 + i);
      ext_prog_data = 8'(i) ^ 8'hA5;
      tick();
    end
    ext_prog_we = 1'b0;
    // blocks 4 to 11 start unprotected
    set_prot(6'h01, 8'h00);
    set_prot(6'h02, 8'h00);
    do_call(8'h01, 8'h05, 8'h00, 8'h00);
    chk_sram(11'h0F9, 8'h00);
    for (int i = 0; i < 128; i++) chk_sram(11'h110 + 11'(i), 8'(i) ^ 8'hA5);
    do_call(8'h02, 8'h09, 8'h00, 8'h00);
    for (int i = 0; i < 128; i++) chk_flash(15'(9 * 128 + i), 8'(i) ^ 8'hA5);
    do_call(8'h03, 8'h09, 8'h00, 8'h00);
    for (int i = 0; i < 128; i++) chk_flash(15'(9 * 128 + i), 8'h00);
    // block 5 read protected, block 9 internal writes disabled
    set_prot(6'h01, 8'h04);
    set_prot(6'h02, 8'h0C);
    do_call(8'h01, 8'h05, 8'h00, 8'h01);
    do_call(8'h02, 8'h09, 8'h00, 8'h01);
    do_call(8'h03, 8'h09, 8'h00, 8'h01);
    // second erase of block 9 with no write between is refused
    call_start = 1'b1;
    tick();
    call_start = 1'b0;
    `CHK(call_refused, 1'b1)
    `CHK(call_busy, 1'b0)
    // mode 10b blocks no service call
    set_prot(6'h02, 8'h08);
    do_call(8'h02, 8'h09, 8'h00, 8'h00);
    chk_flash(15'(9 * 128 + 1), 8'hA4);
    chk_flash(15'(5 * 128), 8'hA5);
    do_call(8'h06, 8'h02, 8'h5C, 8'h10);
    chk_sram(11'h0FF, 8'h17);
    do_call(8'h04, 8'h00, 8'h00, 8'h00);
    `CHK(call_halted, 1'b1)
    end_of_test();
  end
endmodule : testbench
